/* hw/iom_pkg.sv */
// Purpose: Shared constants and types for the general-pin function multiplexer.
// Assumes: AHB-Lite word access; each 8-bit register sits in the low byte of one word.
// Notes:   Register byte address is four times the register index below.
package iom_pkg;

    // Pin count and port layout.
    localparam int NPIN      = 27;
    localparam int NPORT     = 4;
    localparam int PORT_C    = 2;
    localparam int PORT_BITS = 8;

    // Register indices inside the 256-entry window.
    localparam logic [7:0] IDX_DIN [NPORT] = '{8'h00, 8'h01, 8'h10, 8'h11};
    localparam logic [7:0] IDX_CTRL[2]     = '{8'h02, 8'h03};
    localparam logic [7:0] IDX_DOUT[NPORT] = '{8'h04, 8'h05, 8'h12, 8'h13};
    localparam logic [7:0] IDX_DIR [NPORT] = '{8'h06, 8'h07, 8'h14, 8'h15};
    localparam logic [7:0] IDX_OEN [NPORT] = '{8'h0C, 8'h0D, 8'h1A, 8'h1B};
    localparam logic [7:0] IDX_PSEL[NPORT] = '{8'h30, 8'h31, 8'h32, 8'h33};
    localparam logic [7:0] IDX_BCFG        = 8'h34;
    localparam logic [7:0] IDX_JTEN        = 8'hC7;

    // Implemented bits per port; port D has three lines.
    localparam logic [7:0] PORT_MASK[NPORT] = '{8'hFF, 8'hFF, 8'hFF, 8'h07};
    localparam logic [7:0] REG_RST          = 8'h00;

    // Serial programming line positions on port C.
    localparam int JT_TMS  = 0;
    localparam int JT_TCK  = 1;
    localparam int JT_STAT = 3;
    localparam int JT_ERR  = 4;
    localparam int JT_TDI  = 5;
    localparam int JT_TDO  = 6;

    // Bus decode.
    localparam int         IDX_LSB    = 2;
    localparam int         IDX_W      = 8;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // Pin function, one-hot.
    typedef enum logic [4:0] {
        FN_MCU  = 5'h01,
        FN_PLD  = 5'h02,
        FN_ADDR = 5'h04,
        FN_DBUS = 5'h08,
        FN_JTAG = 5'h10
    } iom_fn_e;

    // Pin drive group: level and output enable.
    typedef struct packed {
        logic [NPIN-1:0] val;
        logic [NPIN-1:0] oe;
    } iom_pins_s;

    // Lines handed to the programming logic.
    typedef struct packed {
        logic tms;
        logic tck;
        logic tdi;
    } iom_jtag_req_s;

    // Lines returned from the programming logic.
    typedef struct packed {
        logic tdo;
        logic tdo_oe;
        logic status;
        logic error;
    } iom_jtag_rsp_s;

endpackage

/* hw/iom_pin_cell.sv */
// Purpose: One pin's function selector with registered drive.
// Assumes: The function code is one-hot and stable between changes.
// Notes:   Drive level and enable both come from flip-flops.
`timescale 1ns/100ps
module iom_pin_cell (
    input  wire logic             hclk,     // Bus clock.
    input  wire logic             hresetn,  // Asynchronous reset, active low.
    input  wire iom_pkg::iom_fn_e fn,       // Selected function.
    input  wire logic             mcu_val,  // Processor data-out bit.
    input  wire logic             mcu_oe,   // Processor direction bit.
    input  wire logic             pld_val,  // Logic array output.
    input  wire logic             pld_oe,   // Logic array enable.
    input  wire logic             addr_val, // Latched address bit.
    input  wire logic             dbus_val, // Data bus read bit.
    input  wire logic             dbus_oe,  // Data bus drive enable.
    input  wire logic             jtag_val, // Programming output bit.
    input  wire logic             jtag_oe,  // Programming enable.
    output logic                  pin_val,  // Pin level driven.
    output logic                  pin_oe    // Pin enable, high drives.
);
    import iom_pkg::*;

    logic next_pin_val;
    logic next_pin_oe;

    // Selects level and enable by function.
    always_comb begin
        unique case (fn)
            FN_MCU: begin
                next_pin_val = mcu_val;
                next_pin_oe  = mcu_oe;
            end
            FN_PLD: begin
                next_pin_val = pld_val;
                next_pin_oe  = pld_oe;
            end
            FN_ADDR: begin
                next_pin_val = addr_val;
                next_pin_oe  = 1'b1;
            end
            FN_DBUS: begin
                next_pin_val = dbus_val;
                next_pin_oe  = dbus_oe;
            end
            FN_JTAG: begin
                next_pin_val = jtag_val;
                next_pin_oe  = jtag_oe;
            end
            default: begin
                next_pin_val = 1'b0;
                next_pin_oe  = 1'b0;
            end
        endcase
    end

    // Registers the drive; pins float after reset.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_val <= 1'b0;
            pin_oe  <= 1'b0;
        end else begin
            pin_val <= next_pin_val;
            pin_oe  <= next_pin_oe;
        end
    end

endmodule // iom_pin_cell

/* hw/iom_mux.sv */
// Purpose: Function multiplexer for 27 general pins with an AHB-Lite register window.
// Assumes: Pin inputs and processor address strobes are synchronous to hclk.
// Notes:   Reads take one wait state; writes take none; every answer is OKAY.
// Functional notes
// - 27 pins, four ports, each pin independent.
// - Each pin: processor, logic array, address; here address only on ports A/B.
// - Port C carries TMS, TCK, TDI, TDO.
// - Port C lines 3,4 give status, error.
// - Ports A/B may be processor data bus.
// - Low nibble a3..a0, high nibble a7..a4.
// - Registers sit in a 256-entry window.
// - Control A/B picks processor or address.
// - Direction registers set each pin's direction.
// - Data-out registers drive output pins.
// - Data-in registers read pin levels.
//
// Local design decisions: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
module iom_mux (
    input  wire logic                   hclk,           // Bus clock, 10 MHz.
    input  wire logic                   hresetn,        // Asynchronous reset, active low.
    input  wire logic                   hsel,           // Slave select.
    input  wire logic [31:0]            haddr,          // Byte address.
    input  wire logic [1:0]             htrans,         // Transfer type.
    input  wire logic                   hwrite,         // Write when high.
    input  wire logic [2:0]             hsize,          // Word only.
    input  wire logic [31:0]            hwdata,         // Write data.
    input  wire logic                   hready,         // Bus ready.
    output logic                        hreadyout,      // Slave ready.
    output logic                        hresp,          // Always OKAY.
    output logic [31:0]                 hrdata,         // Read data.
    input  wire logic [iom_pkg::NPIN-1:0] pin_in,       // Pin levels.
    output iom_pkg::iom_pins_s          pins,           // Pin drive and enables.
    input  wire iom_pkg::iom_pins_s     pld_drive,      // Logic array drive.
    input  wire logic [7:0]             mcu_addr,       // Processor low address.
    input  wire logic                   mcu_ale,        // Address latch strobe.
    input  wire logic [7:0]             dbus_drive_data,// Data bus read value.
    input  wire logic                   dbus_drive_en,  // Data bus drive enable.
    output logic [7:0]                  dbus_wdata,     // Data bus sampled from pins.
    output iom_pkg::iom_jtag_req_s      jtag_req,       // Lines to programming logic.
    input  wire iom_pkg::iom_jtag_rsp_s jtag_rsp        // Lines from programming logic.
);
    import iom_pkg::*;

    // Register state.
    logic [1:0][7:0]       ctrl;
    logic [NPORT-1:0][7:0] dout;
    logic [NPORT-1:0][7:0] dir;
    logic [NPORT-1:0][7:0] psel;
    logic [1:0]            bcfg;
    logic                  jt_en;
    logic [7:0]            addr_lat;
    logic                  wr_pend;
    logic                  rd_pend;
    logic [IDX_W-1:0]      idx;
    logic [1:0][7:0]       next_ctrl;
    logic [NPORT-1:0][7:0] next_dout;
    logic [NPORT-1:0][7:0] next_dir;
    logic [NPORT-1:0][7:0] next_psel;
    logic [1:0]            next_bcfg;
    logic                  next_jt_en;
    logic [7:0]            next_addr_lat;
    logic                  next_wr_pend;
    logic                  next_rd_pend;
    logic [IDX_W-1:0]      next_idx;
    logic [31:0]           next_hrdata;
    logic [7:0]            next_dbus_wdata;
    iom_jtag_req_s         next_jtag_req;
    logic [7:0]            rd_val;
    logic [31:0]           pin32;
    logic [31:0]           oe32;
    logic                  accept;
    logic [NPIN-1:0]       cell_val;
    logic [NPIN-1:0]       cell_oe;

    // Padded pin views so every port is a full byte; missing lines read zero.
    assign pin32 = {5'h00, pin_in};
    assign oe32  = {5'h00, cell_oe};
    assign pins  = '{val: cell_val, oe: cell_oe};

    // Bus answers: one wait state on reads only.
    assign hreadyout = ~rd_pend;
    assign hresp     = 1'b0;
    assign accept    = hsel & htrans[1] & hready;

    // Read value of the addressed register; unmapped reads zero.
    always_comb begin
        rd_val = 8'h00;
        for (int p = 0; p < NPORT; p++) begin
            if (idx == IDX_DIN[p])  rd_val = pin32[p*8 +: 8];
            if (idx == IDX_DOUT[p]) rd_val = dout[p];
            if (idx == IDX_DIR[p])  rd_val = dir[p];
            if (idx == IDX_OEN[p])  rd_val = oe32[p*8 +: 8];
            if (idx == IDX_PSEL[p]) rd_val = psel[p];
        end
        for (int p = 0; p < 2; p++) begin
            if (idx == IDX_CTRL[p]) rd_val = ctrl[p];
        end
        if (idx == IDX_BCFG) rd_val = {6'h00, bcfg};
        if (idx == IDX_JTEN) rd_val = {7'h00, jt_en};
    end

    // Next register values: bus phases, register writes, latches and samples.
    always_comb begin
        next_ctrl     = ctrl;
        next_dout     = dout;
        next_dir      = dir;
        next_psel     = psel;
        next_bcfg     = bcfg;
        next_jt_en    = jt_en;
        next_hrdata   = hrdata;
        next_wr_pend  = accept & hwrite;
        next_rd_pend  = accept & ~hwrite;
        next_idx      = accept ? haddr[IDX_LSB +: IDX_W] : idx;
        if (wr_pend) begin
            for (int p = 0; p < NPORT; p++) begin
                if (idx == IDX_DOUT[p]) next_dout[p] = hwdata[7:0] & PORT_MASK[p];
                if (idx == IDX_DIR[p])  next_dir[p]  = hwdata[7:0] & PORT_MASK[p];
                if (idx == IDX_PSEL[p]) next_psel[p] = hwdata[7:0] & PORT_MASK[p];
            end
            for (int p = 0; p < 2; p++) begin
                if (idx == IDX_CTRL[p]) next_ctrl[p] = hwdata[7:0];
            end
            if (idx == IDX_BCFG) next_bcfg  = hwdata[1:0];
            if (idx == IDX_JTEN) next_jt_en = hwdata[0];
        end
        if (rd_pend) next_hrdata = {24'h000000, rd_val};
        next_addr_lat = mcu_ale ? mcu_addr : addr_lat;
        if (bcfg[0])      next_dbus_wdata = pin32[7:0];
        else if (bcfg[1]) next_dbus_wdata = pin32[15:8];
        else              next_dbus_wdata = 8'h00;
        next_jtag_req.tms = jt_en & pin32[PORT_C*8 + JT_TMS];
        next_jtag_req.tck = jt_en & pin32[PORT_C*8 + JT_TCK];
        next_jtag_req.tdi = jt_en & pin32[PORT_C*8 + JT_TDI];
    end

    // Registers every group; all configuration clears at reset.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl       <= '0;
            dout       <= '0;
            dir        <= '0;
            psel       <= '0;
            bcfg       <= 2'h0;
            jt_en      <= 1'b0;
            addr_lat   <= REG_RST;
            wr_pend    <= 1'b0;
            rd_pend    <= 1'b0;
            idx        <= '0;
            hrdata     <= 32'h00000000;
            dbus_wdata <= REG_RST;
            jtag_req   <= '0;
        end else begin
            ctrl       <= next_ctrl;
            dout       <= next_dout;
            dir        <= next_dir;
            psel       <= next_psel;
            bcfg       <= next_bcfg;
            jt_en      <= next_jt_en;
            addr_lat   <= next_addr_lat;
            wr_pend    <= next_wr_pend;
            rd_pend    <= next_rd_pend;
            idx        <= next_idx;
            hrdata     <= next_hrdata;
            dbus_wdata <= next_dbus_wdata;
            jtag_req   <= next_jtag_req;
        end
    end

    // One selector per pin; programming lines win, then data bus, address, logic array.
    for (genvar i = 0; i < NPIN; i++) begin : g_pin
        localparam int  P    = i / PORT_BITS;
        localparam int  B    = i % PORT_BITS;
        localparam bit  IS_J = (P == PORT_C) && (B == JT_TMS || B == JT_TCK || B == JT_STAT ||
                                                B == JT_ERR || B == JT_TDI || B == JT_TDO);
        iom_fn_e fn;
        logic    j_val;
        logic    j_oe;

        // Function choice for this pin.
        always_comb begin
            if (IS_J && jt_en)                fn = FN_JTAG;
            else if (P < 2 && bcfg[P % 2])    fn = FN_DBUS;
            else if (P < 2 && ctrl[P % 2][B]) fn = FN_ADDR;
            else if (psel[P][B])              fn = FN_PLD;
            else                              fn = FN_MCU;
        end

        // Programming drive: status and error out, TDO under its own enable, rest inputs.
        always_comb begin
            j_val = 1'b0;
            j_oe  = 1'b0;
            if (B == JT_STAT) begin
                j_val = jtag_rsp.status;
                j_oe  = 1'b1;
            end
            if (B == JT_ERR) begin
                j_val = jtag_rsp.error;
                j_oe  = 1'b1;
            end
            if (B == JT_TDO) begin
                j_val = jtag_rsp.tdo;
                j_oe  = jtag_rsp.tdo_oe;
            end
        end

        iom_pin_cell u_cell (
            .hclk     (hclk),
            .hresetn  (hresetn),
            .fn       (fn),
            .mcu_val  (dout[P][B]),
            .mcu_oe   (dir[P][B]),
            .pld_val  (pld_drive.val[i]),
            .pld_oe   (pld_drive.oe[i]),
            .addr_val (addr_lat[B]),
            .dbus_val (dbus_drive_data[B]),
            .dbus_oe  (dbus_drive_en),
            .jtag_val (j_val),
            .jtag_oe  (j_oe),
            .pin_val  (cell_val[i]),
            .pin_oe   (cell_oe[i])
        );
    end

endmodule // iom_mux

/* test/iom_mux_properties.sv */
// Purpose: Bus timing and programming-line checks on the pin multiplexer.
// Assumes: hready is tied to hreadyout.
// Notes:   A shadow of the programming enable bit follows bus writes.
`timescale 1ns/100ps
module iom_mux_properties (
    input wire logic                     hclk,      // Bus clock.
    input wire logic                     hresetn,   // Reset, active low.
    input wire logic                     hsel,      // Slave select.
    input wire logic [31:0]              haddr,     // Byte address.
    input wire logic [1:0]               htrans,    // Transfer type.
    input wire logic                     hwrite,    // Write when high.
    input wire logic [31:0]              hwdata,    // Write data.
    input wire logic                     hready,    // Bus ready.
    input wire logic                     hreadyout, // Slave ready.
    input wire logic                     hresp,     // Response.
    input wire logic [31:0]              hrdata,    // Read data.
    input wire logic [iom_pkg::NPIN-1:0] pin_in,    // Pin levels.
    input wire iom_pkg::iom_pins_s       pins,      // Pin drive.
    input wire iom_pkg::iom_jtag_req_s   jtag_req,  // Lines to programming logic.
    input wire iom_pkg::iom_jtag_rsp_s   jtag_rsp   // Lines from programming logic.
);
    import iom_pkg::*;
    logic wr_jt, jt, next_wr_jt, next_jt;
    default clocking cb_d @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Shadow of the enable bit, loaded at the end of the data phase.
    always_comb begin
        next_wr_jt = hsel && htrans[1] && hready && hwrite && (haddr[9:2] == IDX_JTEN);
        next_jt    = wr_jt ? hwdata[0] : jt;
    end
    // Registers the shadow.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_jt <= 1'b0;
            jt    <= 1'b0;
        end else begin
            wr_jt <= next_wr_jt;
            jt    <= next_jt;
        end
    end
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("Response is not OKAY.");
    property p_rd_wait; hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("Read wait state wrong.");
    property p_wr_nowait; hsel && htrans[1] && hready && hwrite |=> hreadyout; endproperty
    a_wr_nowait: assert property (p_wr_nowait) else $error("Write was stalled.");
    property p_rd_upper; $rose(hreadyout) |-> hrdata[31:8] == 24'h0; endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("Read data upper bits set.");
    property p_jt_oe;
        $past(jt) |-> !pins.oe[16] && !pins.oe[17] && !pins.oe[21] && pins.oe[19] && pins.oe[20];
    endproperty
    a_jt_oe: assert property (p_jt_oe) else $error("Programming line enables wrong.");
    property p_jt_stat;
        $past(jt) |-> pins.val[19] == $past(jtag_rsp.status) && pins.val[20] == $past(jtag_rsp.error);
    endproperty
    a_jt_stat: assert property (p_jt_stat) else $error("Status or error line wrong.");
    property p_jt_tdo;
        $past(jt) |-> pins.val[22] == $past(jtag_rsp.tdo) && pins.oe[22] == $past(jtag_rsp.tdo_oe);
    endproperty
    a_jt_tdo: assert property (p_jt_tdo) else $error("Data out line wrong.");
    property p_jt_req;
        jtag_req == ($past(jt) ? {$past(pin_in[16]), $past(pin_in[17]), $past(pin_in[21])} : 3'h0);
    endproperty
    a_jt_req: assert property (p_jt_req) else $error("Programming inputs wrong.");
endmodule // iom_mux_properties
bind iom_mux iom_mux_properties u_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .pin_in, .pins, .jtag_req, .jtag_rsp);

/* test/iom_far_model.sv */
// Purpose: Board and programming logic seen from the pins.
// Assumes: Every line has a pull-up.
// Notes:   Data in is echoed to data out one cycle later.
`timescale 1ns/100ps
module iom_far_model (
    input  wire logic                     hclk,      // Bus clock.
    input  wire logic                     hresetn,   // Reset, active low.
    input  wire iom_pkg::iom_pins_s       pins,      // Device pin drive.
    input  wire logic [iom_pkg::NPIN-1:0] ext_val,   // Board drive level.
    input  wire logic [iom_pkg::NPIN-1:0] ext_oe,    // Board drive enable.
    input  wire logic                     status_in, // Status to report.
    input  wire logic                     error_in,  // Error to report.
    input  wire iom_pkg::iom_jtag_req_s   jtag_req,  // Lines from the device.
    output logic [iom_pkg::NPIN-1:0]      pin_in,    // Resolved pin levels.
    output iom_pkg::iom_jtag_rsp_s        jtag_rsp   // Programming answers.
);
    import iom_pkg::*;
    logic tdo, next_tdo;
    // The device wins a contested line; an undriven line floats to its pull-up.
    always_comb begin
        pin_in   = (pins.oe & pins.val) | (~pins.oe & ext_oe & ext_val) | (~pins.oe & ~ext_oe);
        next_tdo = jtag_req.tdi;
        jtag_rsp = {tdo, 1'b1, status_in, error_in};
    end
    // Registers the echoed bit.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tdo <= 1'b0;
        end else begin
            tdo <= next_tdo;
        end
    end
endmodule // iom_far_model

/* test/io_port_function_mux_tb_top.sv */
// Purpose: Self-checking bench for the pin multiplexer.
// Assumes: Single AHB-Lite master, one slave.
// Notes:   Scenarios run in order; later ones build on register state left by earlier ones.
`timescale 1ns/100ps
module io_port_function_mux_tb_top;
    import iom_pkg::*;
    logic hclk, hresetn, hsel, hwrite, mcu_ale, dbus_drive_en, hreadyout, hresp, st_in, er_in;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [1:0] htrans;
    logic [7:0] mcu_addr, dbus_drive_data, dbus_wdata;
    logic [NPIN-1:0] pin_in, ext_val, ext_oe;
    iom_pins_s pins, pld_drive;
    iom_jtag_req_s jtag_req;
    iom_jtag_rsp_s jtag_rsp;
    int err_total = 0, cmp_count = 0, cyc = 0;
    iom_mux DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hreadyout, .hresp, .hrdata, .pin_in, .pins, .pld_drive, .mcu_addr, .mcu_ale, .dbus_drive_data,
        .dbus_drive_en, .dbus_wdata, .jtag_req, .jtag_rsp);
    iom_far_model FAR (.hclk, .hresetn, .pins, .ext_val, .ext_oe, .status_in(st_in), .error_in(er_in),
        .jtag_req, .pin_in, .jtag_rsp);
    // Clock of 100 ns period.
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    // Cuts a hang short.
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            give_verdict;
        end
    end
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // One single word transfer; read data lands in rdv.
    task automatic ahb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= {22'h0, idx, 2'h0};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask
    task automatic rchk(input logic [7:0] idx, input logic [7:0] e, input string nm);
        ahb(1'b0, idx, 32'h0);
        chk(nm, {24'h0, e}, rdv);
    endtask
    // Compares one port's drive level under a mask, and its enables.
    task automatic pchk(input int p, input logic [7:0] ev, input logic [7:0] em, input logic [7:0] eo,
                        input string nm);
        logic [31:0] v, o;
        v = {5'h0, pins.val};
        o = {5'h0, pins.oe};
        chk(nm, ev & em, v[p*8 +: 8] & em);
        chk(nm, eo, o[p*8 +: 8]);
    endtask
    task automatic t_reset;
        chk("pins_oe", 32'h0, pins.oe);
        for (int p = 0; p < NPORT; p++) begin
            rchk(IDX_DOUT[p], 8'h00, "dout");
            rchk(IDX_DIR[p], 8'h00, "dir");
        end
        rchk(IDX_JTEN, 8'h00, "jten");
    endtask
    task automatic t_mcu;
        for (int p = 0; p < NPORT; p++) begin
            ahb(1'b1, IDX_DOUT[p], 32'hA5);
            ahb(1'b1, IDX_DIR[p], 32'h0F);
            rchk(IDX_DOUT[p], 8'hA5 & PORT_MASK[p], "dout");
            rchk(IDX_OEN[p], 8'h0F & PORT_MASK[p], "oen");
            rchk(IDX_DIN[p], 8'hF5 & PORT_MASK[p], "din");
            pchk(p, 8'hA5 & PORT_MASK[p], 8'hFF, 8'h0F & PORT_MASK[p], "mcu_pins");
        end
    endtask
    task automatic t_addr;
        ahb(1'b1, IDX_CTRL[0], 32'hFF);
        ahb(1'b1, IDX_CTRL[1], 32'h0F);
        mcu_addr <= 8'h3C;
        mcu_ale  <= 1'b1;
        @(posedge hclk);
        mcu_ale  <= 1'b0;
        mcu_addr <= 8'hC3;
        tick(2);
        pchk(0, 8'h3C, 8'hFF, 8'hFF, "addr_a");
        pchk(1, 8'hAC, 8'hFF, 8'h0F, "addr_b");
    endtask
    task automatic t_dbus;
        ahb(1'b1, IDX_BCFG, 32'h01);
        dbus_drive_data <= 8'h96;
        dbus_drive_en   <= 1'b1;
        tick(2);
        pchk(0, 8'h96, 8'hFF, 8'hFF, "dbus_out");
        dbus_drive_en <= 1'b0;
        ext_val[7:0]  <= 8'h69;
        tick(3);
        pchk(0, 8'h00, 8'h00, 8'h00, "dbus_in");
        chk("dbus_wdata", 32'h69, dbus_wdata);
        ext_val[15:8] <= 8'h5A;
        ahb(1'b1, IDX_BCFG, 32'h02);
        tick(3);
        pchk(1, 8'h00, 8'h00, 8'h00, "dbus_b_in");
        chk("dbus_wdata_b", 32'h5A, dbus_wdata);
        dbus_drive_en <= 1'b1;
        tick(2);
        pchk(1, 8'h96, 8'hFF, 8'hFF, "dbus_b_out");
        dbus_drive_en <= 1'b0;
        ahb(1'b1, IDX_BCFG, 32'h00);
    endtask
    task automatic t_pld;
        ahb(1'b1, IDX_PSEL[3], 32'h07);
        pld_drive.val[26:24] <= 3'h6;
        pld_drive.oe[26:24]  <= 3'h3;
        tick(2);
        pchk(3, 8'h06, 8'hFF, 8'h03, "pld_d");
    endtask
    task automatic t_jtag;
        er_in          <= 1'b1;
        ext_val[23:16] <= 8'h21;
        ahb(1'b1, IDX_JTEN, 32'h01);
        tick(4);
        pchk(2, 8'hD4, 8'hDC, 8'h5C, "jtag_on");
        chk("jtag_req", 32'h5, jtag_req);
        rchk(IDX_JTEN, 8'h01, "jten");
        ahb(1'b1, IDX_JTEN, 32'h00);
        tick(2);
        pchk(2, 8'hA5, 8'hFF, 8'h0F, "jtag_off");
        chk("jtag_req_off", 32'h0, jtag_req);
        ahb(1'b1, 8'h50, 32'hFF);
        rchk(8'h50, 8'h00, "unmapped");
    endtask
    // Main sequence.
    initial begin
        {hresetn, hsel, hwrite, mcu_ale, dbus_drive_en, st_in, er_in} = '0;
        {haddr, hwdata, htrans, mcu_addr, dbus_drive_data} = '0;
        ext_val   = '1;
        ext_oe    = '1;
        pld_drive = '0;
        tick(2);
        hresetn <= 1'b1;
        tick(1);
        t_reset;
        t_mcu;
        t_addr;
        t_dbus;
        t_pld;
        t_jtag;
        give_verdict;
    end
endmodule // io_port_function_mux_tb_top
